// *** seep_host.sv ***
// Bus master end: runs random, current and lock-probe sequences on command.
// Assumes software uses the plain register port; makes the link clock itself.
`include "seep_params.svh"

module seep_host (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  seep_if.host             link,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic      [7:0]  rx_data,
  output logic             rx_valid
);
  localparam logic [2:0] QTR_LAST = 3'(`SEEP_QTR_CYC - 1);

  logic                sda_s;
  seep_pkg::seep_hst_t st_r;
  seep_pkg::seep_hst_t st_nxt;
  seep_pkg::seep_op_t  op_r;
  seep_pkg::seep_op_t  op_nxt;
  logic                id_r;
  logic                id_nxt;
  logic [2:0]          cs_r;
  logic [2:0]          cs_nxt;
  logic [15:0]         addr_r;
  logic [15:0]         addr_nxt;
  logic [7:0]          left_r;
  logic [7:0]          left_nxt;
  logic [2:0]          div_r;
  logic [2:0]          div_nxt;
  logic [1:0]          q_r;
  logic [1:0]          q_nxt;
  logic [3:0]          bit_r;
  logic [3:0]          bit_nxt;
  logic [7:0]          tx_r;
  logic [7:0]          tx_nxt;
  logic [7:0]          rx_r;
  logic [7:0]          rx_nxt;
  logic                ackd_r;
  logic                ackd_nxt;
  logic                nack_r;
  logic                nack_nxt;
  logic                lock_r;
  logic                lock_nxt;
  logic                valid_nxt;
  logic [7:0]          data_nxt;
  logic                scl_r;
  logic                scl_nxt;
  logic                low_r;
  logic                low_nxt;
  logic [31:0]         rdata_nxt;
  logic [7:0]          avail;
  logic [3:0]          sel_code;

  seep_sync #(.WIDTH(1)) u_sync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .d       (link.sda),
    .q       (sda_s)
  );

  assign sel_code = id_r ? `SEEP_TYPE_ID : `SEEP_TYPE_ARRAY;
  assign avail    = 8'd31 - {3'b000, addr_r[4:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: each slot is four quarters of the link clock

  always_comb begin
    st_nxt    = st_r;
    op_nxt    = op_r;
    id_nxt    = id_r;
    cs_nxt    = cs_r;
    addr_nxt  = addr_r;
    left_nxt  = left_r;
    div_nxt   = div_r;
    q_nxt     = q_r;
    bit_nxt   = bit_r;
    tx_nxt    = tx_r;
    rx_nxt    = rx_r;
    ackd_nxt  = ackd_r;
    nack_nxt  = nack_r;
    lock_nxt  = lock_r;
    valid_nxt = 1'b0;
    data_nxt  = rx_data;
    if (reg_wr && reg_addr == `SEEP_REG_ADDR) begin
      addr_nxt = reg_wdata[15:0];
    end
    if (reg_wr && reg_addr == `SEEP_REG_CMD && st_r == seep_pkg::HS_IDLE) begin
      op_nxt   = seep_pkg::seep_op_t'(reg_wdata[`SEEP_CMD_OP_LSB +: 2]);
      id_nxt   = reg_wdata[`SEEP_CMD_ID_BIT];
      cs_nxt   = reg_wdata[`SEEP_CMD_CS_LSB +: 3];
      left_nxt = reg_wdata[`SEEP_CMD_CNT_LSB +: 8];
      // Page reads clamped to the page end
      if (reg_wdata[`SEEP_CMD_ID_BIT] && left_nxt > avail) begin
        left_nxt = avail;
      end
      st_nxt   = seep_pkg::HS_START;
      q_nxt    = 2'd0;
      bit_nxt  = 4'h0;
      div_nxt  = QTR_LAST;
      nack_nxt = 1'b0;
    end else if (st_r != seep_pkg::HS_IDLE && div_r != 3'd0) begin
      div_nxt = div_r - 3'd1;
    end else if (st_r != seep_pkg::HS_IDLE) begin
      div_nxt = QTR_LAST;
      q_nxt   = q_r + 2'd1;
      if (q_r == 2'd2 && bit_r == `SEEP_ACK_SLOT) begin
        ackd_nxt = ~sda_s;
      end else if (q_r == 2'd2) begin
        rx_nxt = {rx_r[6:0], sda_s};
      end
      if (q_r == 2'd3) begin
        if (st_r == seep_pkg::HS_START) begin
          // Read bit set only for a current read
          st_nxt = seep_pkg::HS_SEL;
          tx_nxt = {sel_code, cs_r, op_r == seep_pkg::SEEP_OP_CURRENT};
        end else if (st_r == seep_pkg::HS_RST && op_r == seep_pkg::SEEP_OP_PROBE) begin
          st_nxt = seep_pkg::HS_STOP;
        end else if (st_r == seep_pkg::HS_RST) begin
          st_nxt = seep_pkg::HS_SEL2;
          tx_nxt = {sel_code, cs_r, 1'b1};
        end else if (st_r == seep_pkg::HS_STOP) begin
          st_nxt = seep_pkg::HS_IDLE;
        end else if (bit_r != `SEEP_ACK_SLOT) begin
          bit_nxt = bit_r + 4'h1;
        end else begin
          bit_nxt = 4'h0;
          case (st_r)
            seep_pkg::HS_SEL: begin
              // Random read by dummy write by default
              st_nxt = (op_r == seep_pkg::SEEP_OP_CURRENT) ? seep_pkg::HS_RD
                                                            : seep_pkg::HS_ADH;
              tx_nxt = addr_r[15:8];
            end
            seep_pkg::HS_ADH: begin
              st_nxt = seep_pkg::HS_ADL;
              tx_nxt = addr_r[7:0];
            end
            seep_pkg::HS_ADL: begin
              st_nxt = (op_r == seep_pkg::SEEP_OP_PROBE) ? seep_pkg::HS_WD
                                                          : seep_pkg::HS_RST;
              tx_nxt = 8'h00;
            end
            seep_pkg::HS_WD: begin
              lock_nxt = ackd_r;
              st_nxt   = seep_pkg::HS_RST;
            end
            seep_pkg::HS_SEL2: st_nxt = seep_pkg::HS_RD;
            default: begin
              valid_nxt = 1'b1;
              data_nxt  = rx_r;
              left_nxt  = left_r - 8'd1;
              // Last byte was nacked, so stop
              st_nxt    = (left_r == 8'd0) ? seep_pkg::HS_STOP : seep_pkg::HS_RD;
            end
          endcase
          if (st_r != seep_pkg::HS_RD && st_r != seep_pkg::HS_WD && !ackd_r) begin
            nack_nxt = 1'b1;
            st_nxt   = seep_pkg::HS_STOP;
          end
        end
      end
    end
    // Line levels for the slot that the next quarter belongs to
    scl_nxt = 1'b1;
    low_nxt = 1'b0;
    if (st_nxt == seep_pkg::HS_START || st_nxt == seep_pkg::HS_RST) begin
      scl_nxt = (q_nxt == 2'd1 || q_nxt == 2'd2);
      low_nxt = q_nxt[1];
    end else if (st_nxt == seep_pkg::HS_STOP) begin
      scl_nxt = (q_nxt != 2'd0);
      low_nxt = ~q_nxt[1];
    end else if (st_nxt != seep_pkg::HS_IDLE) begin
      scl_nxt = (q_nxt == 2'd1 || q_nxt == 2'd2);
      if (st_nxt == seep_pkg::HS_RD) begin
        // Ack every byte but the last
        low_nxt = (bit_nxt == `SEEP_ACK_SLOT) && (left_nxt != 8'd0);
      end else if (bit_nxt != `SEEP_ACK_SLOT) begin
        low_nxt = ~tx_nxt[3'd7 - bit_nxt[2:0]];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (!reg_rd) begin
      rdata_nxt = 32'h0000_0000;
    end else if (reg_addr == `SEEP_REG_CMD) begin
      rdata_nxt = {16'h0000, left_r, 2'b00, cs_r, id_r, op_r};
    end else if (reg_addr == `SEEP_REG_ADDR) begin
      rdata_nxt = {16'h0000, addr_r};
    end else if (reg_addr == `SEEP_REG_STAT) begin
      rdata_nxt[`SEEP_STAT_BUSY] = (st_r != seep_pkg::HS_IDLE);
      rdata_nxt[`SEEP_STAT_NACK] = nack_r;
      rdata_nxt[`SEEP_STAT_LOCK] = lock_r;
    end else if (reg_addr == `SEEP_REG_RDATA) begin
      rdata_nxt = {24'h000000, rx_data};
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r      <= seep_pkg::HS_IDLE;
      op_r      <= seep_pkg::SEEP_OP_RANDOM;
      id_r      <= 1'b0;
      cs_r      <= 3'b000;
      addr_r    <= 16'h0000;
      left_r    <= 8'h00;
      div_r     <= 3'd0;
      q_r       <= 2'd0;
      bit_r     <= 4'h0;
      tx_r      <= 8'h00;
      rx_r      <= 8'h00;
      ackd_r    <= 1'b0;
      nack_r    <= 1'b0;
      lock_r    <= 1'b0;
      rx_valid  <= 1'b0;
      rx_data   <= 8'h00;
      scl_r     <= 1'b1;
      low_r     <= 1'b0;
      reg_rdata <= 32'h0000_0000;
    end else begin
      st_r      <= st_nxt;
      op_r      <= op_nxt;
      id_r      <= id_nxt;
      cs_r      <= cs_nxt;
      addr_r    <= addr_nxt;
      left_r    <= left_nxt;
      div_r     <= div_nxt;
      q_r       <= q_nxt;
      bit_r     <= bit_nxt;
      tx_r      <= tx_nxt;
      rx_r      <= rx_nxt;
      ackd_r    <= ackd_nxt;
      nack_r    <= nack_nxt;
      lock_r    <= lock_nxt;
      rx_valid  <= valid_nxt;
      rx_data   <= data_nxt;
      scl_r     <= scl_nxt;
      low_r     <= low_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

  assign link.scl           = scl_r;
  assign link.sda_host_o    = 1'b0;
  assign link.sda_host_oe_n = ~low_r;
endmodule

// *** seep_params.svh ***
// Constants for the serial EEPROM read path: codes, sizes, timing, host map.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef SEEP_PARAMS_SVH
`define SEEP_PARAMS_SVH

`define SEEP_TYPE_ARRAY  4'ha
`define SEEP_TYPE_ID     4'hb
`define SEEP_ARRAY_BYTES 8192
`define SEEP_ID_BYTES    32
`define SEEP_ERASED      8'hff
`define SEEP_ACK_SLOT    4'h8
`define SEEP_ACK_DONE    4'h9

`define SEEP_REF_NS      40
`define SEEP_SCL_NS      640
`define SEEP_QTR_CYC     ((`SEEP_SCL_NS + 4 * `SEEP_REF_NS - 1) / (4 * `SEEP_REF_NS))

`define SEEP_REG_CMD     4'h0
`define SEEP_REG_ADDR    4'h4
`define SEEP_REG_STAT    4'h8
`define SEEP_REG_RDATA   4'hc
`define SEEP_CMD_OP_LSB  0
`define SEEP_CMD_ID_BIT  2
`define SEEP_CMD_CS_LSB  3
`define SEEP_CMD_CNT_LSB 8
`define SEEP_STAT_BUSY   0
`define SEEP_STAT_NACK   1
`define SEEP_STAT_LOCK   2

`endif

// *** seep_pkg.sv ***
// Types shared by both ends of the serial EEPROM read path.
// Assumes nothing; compiled first.
package seep_pkg;
  typedef enum logic [1:0] {SEEP_OP_RANDOM, SEEP_OP_CURRENT, SEEP_OP_PROBE} seep_op_t;
  typedef enum logic [2:0] {DS_IDLE, DS_SEL, DS_ADH, DS_ADL, DS_WDAT, DS_RD} seep_dst_t;
  typedef enum logic [3:0] {
    HS_IDLE, HS_START, HS_SEL, HS_ADH, HS_ADL, HS_WD, HS_RST, HS_SEL2, HS_RD, HS_STOP
  } seep_hst_t;
endpackage

// *** seep_if.sv ***
// Two-wire link between the bus master and the EEPROM read path.
// Assumes the bench joins both modports; the wire level is resolved here.
interface seep_if;
  logic scl;
  logic sda;
  logic sda_dev_o;
  logic sda_dev_oe_n;
  logic sda_host_o;
  logic sda_host_oe_n;

  // Open drain with pull-up: any enabled low driver wins
  assign sda = (sda_dev_oe_n | sda_dev_o) & (sda_host_oe_n | sda_host_o);

  modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe_n);
  modport host (output scl, input sda, output sda_host_o, output sda_host_oe_n);
endinterface

// *** seep_sync.sv ***
// Two-flop synchroniser for pin-level inputs.
// Assumes inputs are quasi-static levels; no pulse shorter than two clocks.
module seep_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// *** seep_dev.sv ***
// EEPROM end of the link: select decode, address load, array and page reads.
// Assumes ref_clk is much faster than the link clock; pins arrive unsynchronised.
`include "seep_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Reads ignore the write-protect input
// - Counter advances by one per read byte
// - Release data line, sample ack on ninth
// - Missing ack ends output, back to standby
// - Random read: dummy write, repeated Start, read
// - Read select after dummy load returns loaded byte
// - Single random read ends with nack, Stop
// - Current read returns counter byte, then increments
// - One counter shared by array and page
// - Master should prefer random reads for array
// - Acked bytes continue with next consecutive byte
// - Sequential read ends with nack, Stop
// - Counter wraps to zero past top address
// - Page read uses type 1011b, low five bits
// - Master keeps page reads inside 32 bytes
// - Truncated page write acked only if unlocked
// - Start discards pending command; Stop gives standby
// - Master follows lock probe with Start, Stop
// - Initial content reads all ones everywhere
// - Respond only when strap bits match code
// - Eighth select bit: one read, zero write
// - Write select takes two acked address bytes
// - Busy write cycle: ignore bus, no ack
module seep_dev (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  seep_if.dev              link,
  input  wire logic        chip_select_strap_2,
  input  wire logic        chip_select_strap_1,
  input  wire logic        chip_select_strap_0,
  input  wire logic        write_protect_input,
  input  wire logic        id_page_locked,
  input  wire logic        write_cycle_busy,
  input  wire logic        load_we,
  input  wire logic        load_id,
  input  wire logic [12:0] load_addr,
  input  wire logic [7:0]  load_data,
  output logic      [12:0] addr_count,
  output logic             selected
);
  logic [7:0]         pins_s;
  logic               scl_s;
  logic               sda_s;
  logic [2:0]         straps_s;
  logic               wp_s;
  logic               locked_s;
  logic               busy_s;
  logic               scl_d_r;
  logic               sda_d_r;
  logic               rise;
  logic               fall;
  logic               start_seen;
  logic               stop_seen;
  seep_pkg::seep_dst_t state_r;
  seep_pkg::seep_dst_t state_nxt;
  logic [3:0]         cnt_r;
  logic [3:0]         cnt_nxt;
  logic [7:0]         sr_r;
  logic [7:0]         sr_nxt;
  logic [7:0]         hi_r;
  logic [7:0]         hi_nxt;
  logic [12:0]        addr_r;
  logic [12:0]        addr_nxt;
  logic               drive_r;
  logic               drive_nxt;
  logic               ack_r;
  logic               ack_nxt;
  logic               id_r;
  logic               id_nxt;
  logic               rw_r;
  logic               rw_nxt;
  logic [7:0]         arr_mem [0:`SEEP_ARRAY_BYTES-1];
  logic [7:0]         id_mem [0:`SEEP_ID_BYTES-1];
  logic [`SEEP_ARRAY_BYTES-1:0] arr_ok_r;
  logic [`SEEP_ID_BYTES-1:0]    id_ok_r;
  logic [7:0]         rd_byte;
  logic               sel_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling and bus condition detection

  seep_sync #(.WIDTH(8)) u_sync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .d       ({link.scl, link.sda, chip_select_strap_2, chip_select_strap_1,
               chip_select_strap_0, write_protect_input, id_page_locked,
               write_cycle_busy}),
    .q       (pins_s)
  );

  assign scl_s      = pins_s[7];
  assign sda_s      = pins_s[6];
  assign straps_s   = pins_s[5:3];
  assign wp_s       = pins_s[2];
  assign locked_s   = pins_s[1];
  assign busy_s     = pins_s[0];
  assign rise       = scl_s & ~scl_d_r;
  assign fall       = ~scl_s & scl_d_r;
  assign start_seen = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_seen  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Storage; a location never loaded reads as erased

  always_ff @(posedge ref_clk) begin
    if (load_we && load_id) begin
      id_mem[load_addr[4:0]] <= load_data;
    end else if (load_we) begin
      arr_mem[load_addr] <= load_data;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      arr_ok_r <= '0;
      id_ok_r  <= '0;
    end else if (load_we && load_id) begin
      id_ok_r[load_addr[4:0]] <= 1'b1;
    end else if (load_we) begin
      arr_ok_r[load_addr] <= 1'b1;
    end
  end

  // Page reads use only the low five counter bits
  always_comb begin
    rd_byte = `SEEP_ERASED;
    if (id_r && id_ok_r[addr_r[4:0]]) begin
      rd_byte = id_mem[addr_r[4:0]];
    end else if (!id_r && arr_ok_r[addr_r]) begin
      rd_byte = arr_mem[addr_r];
    end
  end

  // Type, strap match and not busy
  assign sel_ok = (sr_r[7:4] == `SEEP_TYPE_ARRAY || sr_r[7:4] == `SEEP_TYPE_ID)
                  && sr_r[3:1] == straps_s && !busy_s;

  ////////////////////////////////////////////////////////////////////////////
  // Protocol engine

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    sr_nxt    = sr_r;
    hi_nxt    = hi_r;
    addr_nxt  = addr_r;
    drive_nxt = drive_r;
    ack_nxt   = ack_r;
    id_nxt    = id_r;
    rw_nxt    = rw_r;
    if (start_seen) begin
      // Any half-received command is dropped
      state_nxt = seep_pkg::DS_SEL;
      cnt_nxt   = 4'h0;
      drive_nxt = 1'b0;
    end else if (stop_seen) begin
      state_nxt = seep_pkg::DS_IDLE;
      cnt_nxt   = 4'h0;
      drive_nxt = 1'b0;
    end else if (state_r == seep_pkg::DS_RD) begin
      // Write protect plays no part in this path
      if (rise) begin
        if (cnt_r == `SEEP_ACK_SLOT) begin
          ack_nxt  = ~sda_s;
          // Natural 13-bit wrap to address zero
          addr_nxt = addr_r + 13'h0001;
        end
        cnt_nxt = cnt_r + 4'h1;
      end else if (fall) begin
        if (cnt_r == `SEEP_ACK_SLOT) begin
          drive_nxt = 1'b0;
        end else if (cnt_r == `SEEP_ACK_DONE && ack_r) begin
          sr_nxt    = rd_byte;
          drive_nxt = ~rd_byte[7];
          cnt_nxt   = 4'h0;
        end else if (cnt_r == `SEEP_ACK_DONE) begin
          state_nxt = seep_pkg::DS_IDLE;
          drive_nxt = 1'b0;
        end else begin
          drive_nxt = ~sr_r[3'd7 - cnt_r[2:0]];
        end
      end
    end else if (state_r != seep_pkg::DS_IDLE) begin
      if (rise) begin
        if (cnt_r < `SEEP_ACK_SLOT) begin
          sr_nxt = {sr_r[6:0], sda_s};
        end
        cnt_nxt = cnt_r + 4'h1;
      end else if (fall && cnt_r == `SEEP_ACK_SLOT) begin
        case (state_r)
          seep_pkg::DS_SEL: begin
            ack_nxt = sel_ok;
            id_nxt  = (sr_r[7:4] == `SEEP_TYPE_ID);
            rw_nxt  = sr_r[0];
          end
          seep_pkg::DS_ADH: begin
            ack_nxt = 1'b1;
            hi_nxt  = sr_r;
          end
          seep_pkg::DS_ADL: begin
            ack_nxt = 1'b1;
            // Page access leaves its byte slot in the shared counter
            if (id_r) begin
              addr_nxt = {8'h00, sr_r[4:0]};
            end else begin
              addr_nxt = {hi_r[4:0], sr_r};
            end
          end
          default: begin
            // Data byte is never stored; its ack reports lock for a page, write protect for the array
            ack_nxt = id_r ? ~locked_s : ~wp_s;
          end
        endcase
        drive_nxt = (state_r == seep_pkg::DS_SEL) ? sel_ok : 1'b1;
        if (state_r == seep_pkg::DS_WDAT) begin
          drive_nxt = id_r ? ~locked_s : ~wp_s;
        end
      end else if (fall && cnt_r == `SEEP_ACK_DONE) begin
        drive_nxt = 1'b0;
        cnt_nxt   = 4'h0;
        if (!ack_r && state_r == seep_pkg::DS_SEL) begin
          state_nxt = seep_pkg::DS_IDLE;
        end else begin
          case (state_r)
            seep_pkg::DS_SEL: begin
              if (rw_r) begin
                // Read select: ack given, first bit now
                state_nxt = seep_pkg::DS_RD;
                sr_nxt    = rd_byte;
                drive_nxt = ~rd_byte[7];
              end else begin
                state_nxt = seep_pkg::DS_ADH;
              end
            end
            seep_pkg::DS_ADH: state_nxt = seep_pkg::DS_ADL;
            default:          state_nxt = seep_pkg::DS_WDAT;
          endcase
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= seep_pkg::DS_IDLE;
      cnt_r   <= 4'h0;
      sr_r    <= 8'h00;
      hi_r    <= 8'h00;
      addr_r  <= 13'h0000;
      drive_r <= 1'b0;
      ack_r   <= 1'b0;
      id_r    <= 1'b0;
      rw_r    <= 1'b0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      sr_r    <= sr_nxt;
      hi_r    <= hi_nxt;
      addr_r  <= addr_nxt;
      drive_r <= drive_nxt;
      ack_r   <= ack_nxt;
      id_r    <= id_nxt;
      rw_r    <= rw_nxt;
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign link.sda_dev_o    = 1'b0;
  assign link.sda_dev_oe_n = ~drive_r;
  assign addr_count        = addr_r;
  assign selected          = (state_r != seep_pkg::DS_IDLE);
endmodule

// *** seep_link_assertions.sv ***
// Checker for the two-wire link joining host and device ends.
// Assumes one instance beside the interface; one clock domain only.
module seep_link_checker (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe_n,
  input wire logic sda_host_oe_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] low_r;
  logic [7:0] low_nxt;
  // Saturate so a stuck driver cannot wrap back under the bound
  always_comb low_nxt = sda_dev_oe_n ? 8'h0 : (low_r == 8'hff ? low_r : low_r + 8'h1);
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) low_r <= 8'h0;
    else low_r <= low_nxt;
  end
  sequence s_low4; !scl [*4]; endsequence
  sequence s_start; scl && $fell(sda); endsequence
  sequence s_stop; scl && $past(scl) && $rose(sda); endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_dev_open_drain:
    assert property (sda_dev_o == 1'b0) else $error("device drives sda high");
  a_pull_wins:
    assert property (!sda_dev_oe_n |-> !sda) else $error("sda high while device pulls");
  a_idle_high:
    assert property (sda_dev_oe_n && sda_host_oe_n |-> sda) else $error("sda low released");
  a_dev_moves_low:
    assert property ($changed(sda_dev_oe_n) |-> !scl) else $error("device moved sda, scl high");
  a_release_ninth:
    assert property (low_r <= 8'd144) else $error("device held sda low too long");
  a_scl_low_min:
    assert property ($fell(scl) |-> s_low4) else $error("scl low phase too short");
  a_reset_idle:
    assert property ($fell(sys_rst) |-> scl && sda_dev_oe_n && sda_host_oe_n)
      else $error("link not idle after reset");
  a_stop_standby:
    assert property (s_stop |=> sda_dev_oe_n [*8]) else $error("device drives after stop");
  a_start_listens:
    assert property (s_start |=> sda_dev_oe_n [*8]) else $error("device drives after start");
endmodule

// *** tb_top.sv ***
// Bench joining both ends; reads run through the host's register port.
// Assumes the host makes the link clock; memory preloaded through load_*.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, rx_valid, selected;
  logic        wp = 0, locked = 0, wbusy = 0, ld_we = 0, ld_id = 0;
  logic [3:0]  reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, st;
  logic [7:0]  rx_data, ld_d = '0;
  logic [12:0] ld_a = '0, addr_count;
  logic [7:0]  rxq[$];
  int          miscompares = 0, tests_run = 0, cyc = 0;
  seep_if link ();
  seep_dev i_seep_dev (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link),
    .chip_select_strap_2(1'b1), .chip_select_strap_1(1'b0), .chip_select_strap_0(1'b1),
    .write_protect_input(wp), .id_page_locked(locked), .write_cycle_busy(wbusy),
    .load_we(ld_we), .load_id(ld_id), .load_addr(ld_a), .load_data(ld_d),
    .addr_count(addr_count), .selected(selected));
  seep_host i_seep_host (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_data(rx_data), .rx_valid(rx_valid));
  seep_link_checker i_seep_link_checker (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .scl(link.scl), .sda(link.sda), .sda_dev_o(link.sda_dev_o),
    .sda_dev_oe_n(link.sda_dev_oe_n), .sda_host_oe_n(link.sda_host_oe_n));
  initial forever #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
    cyc <= cyc + 1;
    // Whole run needs about 4800 cycles
    if (cyc == 40000) begin
      miscompares++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 0;
  endtask
  task automatic rd(logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask
  task automatic ld(logic id, logic [12:0] a, logic [7:0] d);
    @(posedge ref_clk);
    ld_we <= 1;
    ld_id <= id;
    ld_a <= a;
    ld_d <= d;
    @(posedge ref_clk);
    ld_we <= 0;
  endtask
  // Op, page flag, chip bits, byte count less one
  task automatic run(logic [1:0] op, logic id, logic [2:0] cs, logic [7:0] n, logic [15:0] a);
    rxq = {};
    wr(4'h4, {16'h0, a});
    wr(4'h0, {16'h0, n, 2'h0, cs, id, op});
    st = 32'h1;
    for (int i = 0; i < 3000 && st[0] !== 1'b0; i++) rd(4'h8, st);
    chk("idle", st[0], 1'b0);
  endtask
  task automatic t_random();
    run(2'h0, 1'b0, 3'h5, 8'h0, 16'h0010);
    chk("erased", rxq[0], 8'hff);
    chk("one byte", rxq.size(), 1);
    chk("standby", selected, 1'b0);
    ld(0, 13'h1fff, 8'ha5);
    ld(0, 13'h0, 8'h5a);
    wp <= 1;
    run(2'h0, 1'b0, 3'h5, 8'h1, 16'h1fff);
    chk("top byte", rxq[0], 8'ha5);
    chk("wrapped", rxq[1], 8'h5a);
    chk("counter", addr_count, 13'h1);
    $display("random and wrap done");
  endtask
  task automatic t_current();
    ld(0, 13'h1, 8'h3c);
    run(2'h1, 1'b0, 3'h5, 8'h0, 16'h0);
    chk("current", rxq[0], 8'h3c);
    chk("counter", addr_count, 13'h2);
    rd(4'hc, st);
    chk("rdata", st[7:0], 8'h3c);
    $display("current done");
  endtask
  task automatic t_page();
    ld(1, 13'h5, 8'hc3);
    ld(0, 13'h6, 8'h69);
    run(2'h0, 1'b1, 3'h5, 8'h0, 16'hffe5);
    chk("page", rxq[0], 8'hc3);
    run(2'h1, 1'b0, 3'h5, 8'h0, 16'h0);
    chk("shared", rxq[0], 8'h69);
    $display("page done");
  endtask
  task automatic t_refuse();
    run(2'h1, 1'b0, 3'h4, 8'h0, 16'h0);
    chk("strap", st[1], 1'b1);
    @(posedge ref_clk);
    wbusy <= 1;
    run(2'h1, 1'b0, 3'h5, 8'h0, 16'h0);
    chk("busy", st[1], 1'b1);
    @(posedge ref_clk);
    wbusy <= 0;
    $display("refuse done");
  endtask
  task automatic t_probe();
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      locked <= k[0];
      run(2'h2, 1'b1, 3'h5, 8'h0, 16'h0);
      chk("lock", st[2], !k[0]);
      chk("standby", selected, 1'b0);
    end
    $display("probe done");
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    sys_rst <= 0;
    repeat (6) @(posedge ref_clk);
    t_random();
    t_current();
    t_page();
    t_refuse();
    t_probe();
    complete_run();
  end
endmodule
